// file: shared/ecc_pkg.sv
`default_nettype none
package ecc_pkg;
  // ---------------------------------------------------------------
  // i/o space locations
  // ---------------------------------------------------------------
  localparam logic [5:0] ADDR_OFS = 6'h1e;
  localparam logic [5:0] DATA_OFS = 6'h1d;
  localparam logic [5:0] CTRL_OFS = 6'h1c;
  // ---------------------------------------------------------------
  // control register fields
  // ---------------------------------------------------------------
  localparam int CTRL_RD_BIT   = 0;
  localparam int CTRL_WR_BIT   = 1;
  localparam int CTRL_ARM_BIT  = 2;
  localparam int CTRL_RIE_BIT  = 3;
  localparam logic [3:0] CTRL_RST = 4'h0;
  // ---------------------------------------------------------------
  // sizes and timing
  // ---------------------------------------------------------------
  localparam int AW           = 6;
  localparam int DEPTH        = 64;
  localparam int WR_OSC_CYC   = 4096;
  localparam int WR_STALL_CYC = 2;
  localparam int RD_STALL_CYC = 4;
  localparam int ARM_CYC      = 4;
  localparam real WR_TIME_MIN_MS = 3.1;
  localparam real WR_TIME_MAX_MS = 6.8;
  localparam real CLK_MHZ        = 200.0;
  typedef enum logic [1:0] {ECC_IDLE, ECC_WRITE} ecc_wstate_t;
endpackage
`default_nettype wire

// file: testbench/ecc_cpu_model.sv
`default_nettype none
// ---------------------------------------------------------------
// cpu side of the i/o space, one access per call
// ---------------------------------------------------------------
module ecc_cpu_model (
  // clock
  input  wire logic       i_clk,
  // i/o space
  output logic      [5:0] o_addr,
  output logic            o_wr,
  output logic      [7:0] o_wdata,
  output logic            o_rd,
  input  wire logic [7:0] i_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_addr  = 6'h00;
    o_wr    = 1'b0;
    o_wdata = 8'h00;
    o_rd    = 1'b0;
  end
  // idle bus shows inverted values so a stale address cannot pass unseen
  task automatic wr_io(input logic [5:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_addr  = a;
    o_wdata = d;
    o_wr    = 1'b1;
    @(negedge i_clk);
    o_wr    = 1'b0;
    o_addr  = ~a;
    o_wdata = ~d;
  endtask
  task automatic rd_io(input logic [5:0] a, output logic [7:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_rd   = 1'b1;
    @(negedge i_clk);
    o_rd   = 1'b0;
    d      = i_rdata;
    o_addr = ~a;
  endtask
endmodule
`default_nettype wire

// file: testbench/eeprom_cpu_access_ctrl_tb.sv
`default_nettype none
module eeprom_cpu_access_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ecc_pkg::*;
  logic       clk, rstn, ce, gie, wr, rd, stall, irq;
  logic       tick = 1'b0;
  logic [5:0] addr;
  logic [7:0] wdata, rdata, v;
  int         miscompares, check_count, cyc, stalls, t0;
  ecc_ctrl DUT (.i_clk(clk), .i_rstn(rstn), .i_ce(ce), .i_osc_tick(tick),
    .i_io_addr(addr), .i_io_wr(wr), .i_io_wdata(wdata), .i_io_rd(rd),
    .o_io_rdata(rdata), .i_global_ie(gie), .o_cpu_stall(stall), .o_ready_irq(irq));
  ecc_cpu_model cpu (.i_clk(clk), .o_addr(addr), .o_wr(wr), .o_wdata(wdata),
    .o_rd(rd), .i_rdata(rdata));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // oscillator tick every second clock: 4096 ticks take 8192 cycles
  // driven and sampled on the falling edge, away from the edge that launches outputs
  always @(negedge clk) begin
    cyc++;
    tick = ~tick;
    if (stall === 1'b1) stalls++;
    if (cyc == 30000) begin
      miscompares++;
      stop_test();
    end
  end
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 5000; i++) begin
      cpu.rd_io(CTRL_OFS, v);
      if (v[1] === 1'b0) break;
    end
  endtask
  task automatic pulse_reset();
    rstn = 1'b0;
    repeat (5) @(negedge clk);
    rstn = 1'b1;
  endtask
  task automatic t_regs();
    cpu.wr_io(ADDR_OFS, 8'hff);
    cpu.rd_io(ADDR_OFS, v);
    chk("addr", 8'h3f, v);
    cpu.wr_io(CTRL_OFS, 8'hf8);
    cpu.rd_io(CTRL_OFS, v);
    chk("ctrl", 8'h08, v);
    gie = 1'b1;
    repeat (3) @(negedge clk);
    chk("irq", 8'h01, {7'h0, irq});
    gie = 1'b0;
    $display("test regs done");
  endtask
  // interrupts kept off while arming, as software must
  task automatic t_write(logic [5:0] a, logic [7:0] d);
    wait_idle();
    cpu.wr_io(ADDR_OFS, {2'b00, a});
    cpu.wr_io(DATA_OFS, d);
    cpu.wr_io(CTRL_OFS, 8'h0c);
    stalls = 0;
    cpu.wr_io(CTRL_OFS, 8'h0a);
    t0 = cyc;
    repeat (3) @(negedge clk);
    chk("wstall", 8'd2, 8'(stalls));
    gie = 1'b1;
    cpu.rd_io(CTRL_OFS, v);
    chk("busy", 8'h0a, v);
    chk("irqbusy", 8'h00, {7'h0, irq});
    wait_idle();
    chk("wtime", 8'h01, {7'h0, (cyc - t0 > 2 * WR_OSC_CYC - 12)
      && (cyc - t0 < 2 * WR_OSC_CYC + 28)});
    repeat (2) @(negedge clk);
    chk("irqdone", 8'h01, {7'h0, irq});
    gie = 1'b0;
    $display("test write done");
  endtask
  task automatic t_read(logic [5:0] a, logic [7:0] d);
    cpu.wr_io(ADDR_OFS, {2'b00, a});
    stalls = 0;
    cpu.wr_io(CTRL_OFS, 8'h01);
    repeat (5) @(negedge clk);
    chk("rstall", 8'd4, 8'(stalls));
    cpu.rd_io(DATA_OFS, v);
    chk("rdata", d, v);
    cpu.rd_io(CTRL_OFS, v);
    chk("rdone", 8'h00, v);
    $display("test read done");
  endtask
  task automatic t_refuse();
    cpu.wr_io(CTRL_OFS, 8'h02);
    cpu.rd_io(CTRL_OFS, v);
    chk("noarm", 8'h00, v);
    cpu.wr_io(CTRL_OFS, 8'h04);
    cpu.rd_io(CTRL_OFS, v);
    chk("arm", 8'h04, v);
    repeat (4) @(negedge clk);
    cpu.wr_io(CTRL_OFS, 8'h02);
    cpu.rd_io(CTRL_OFS, v);
    chk("late", 8'h00, v);
    $display("test refuse done");
  endtask
  task automatic t_abort();
    cpu.wr_io(DATA_OFS, 8'h3c);
    cpu.wr_io(CTRL_OFS, 8'h04);
    cpu.wr_io(CTRL_OFS, 8'h02);
    repeat (20) @(negedge clk);
    cpu.wr_io(DATA_OFS, 8'h11);
    cpu.rd_io(CTRL_OFS, v);
    chk("abort", 8'h00, v);
    t_read(6'h05, 8'ha5);
    cpu.wr_io(DATA_OFS, 8'h77);
    cpu.wr_io(CTRL_OFS, 8'h04);
    cpu.wr_io(CTRL_OFS, 8'h02);
    repeat (20) @(negedge clk);
    pulse_reset();
    cpu.rd_io(CTRL_OFS, v);
    chk("rstctrl", 8'h00, v);
    cpu.rd_io(ADDR_OFS, v);
    chk("rstaddr", 8'h05, v);
    repeat (2 * WR_OSC_CYC + 100) @(negedge clk);
    t_read(6'h05, 8'ha5);
    $display("test abort done");
  endtask
  // a low enable freezes the arm countdown, so a strobe after the pause still lands
  task automatic t_freeze();
    cpu.wr_io(CTRL_OFS, 8'h04);
    ce = 1'b0;
    repeat (6) @(negedge clk);
    ce = 1'b1;
    cpu.wr_io(CTRL_OFS, 8'h02);
    cpu.rd_io(CTRL_OFS, v);
    chk("frozen", 8'h06, v);
    cpu.wr_io(ADDR_OFS, 8'h05);
    cpu.rd_io(CTRL_OFS, v);
    chk("addrabort", 8'h00, v);
    t_read(6'h05, 8'ha5);
    $display("test freeze done");
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    gie  = 1'b0;
    ce   = 1'b1;
    rstn = 1'b0;
    repeat (5) @(negedge clk);
    rstn = 1'b1;
    t_regs();
    t_write(6'h05, 8'ha5);
    t_read(6'h05, 8'ha5);
    t_refuse();
    t_abort();
    t_freeze();
    stop_test();
  end
endmodule
`default_nettype wire

// file: verilog/ecc_ctrl.sv
`default_nettype none
// Operation
// - write duration counted as 4096 calibrated oscillator cycles.
// - a launched write stalls the cpu for two clock cycles.
// - a launched read stalls the cpu for four clock cycles.
// - address holds 6 bits for 0..63; upper two bits read zero.
// - reset does not clear the address register.
// - data register supplies written byte and receives read byte.
// - control register upper four bits always read zero.
// - interrupt enable and global flag give level irq while write strobe is zero.
// - write strobe starts a write only while arm bit is set.
// - arm bit clears itself four clock cycles after being set.
// - write strobe stays set during write, hardware clears at end.
// - read strobe fetches byte into data and clears itself.
// - writing address or data during a write aborts it.
module ecc_ctrl
  import ecc_pkg::*;
(
  // clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_rstn,
  input  wire logic                 i_ce,
  // calibrated rc oscillator tick, synchronous single-cycle pulse
  input  wire logic                 i_osc_tick,
  // cpu i/o space access
  input  wire logic [5:0]           i_io_addr,
  input  wire logic                 i_io_wr,
  input  wire logic [7:0]           i_io_wdata,
  input  wire logic                 i_io_rd,
  output logic      [7:0]           o_io_rdata,
  // cpu status and stall
  input  wire logic                 i_global_ie,
  output logic                      o_cpu_stall,
  output logic                      o_ready_irq
);
  import ecc_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0]        mem [DEPTH];
  logic [AW-1:0]     addr_r;
  logic [AW-1:0]     addr_nxt;
  logic [7:0]        data_r;
  logic [7:0]        data_nxt;
  logic              rie_r,  rie_nxt;
  logic              arm_r,  arm_nxt;
  logic              wr_r,   wr_nxt;
  logic [2:0]        arm_cnt_r, arm_cnt_nxt;
  logic [12:0]       osc_cnt_r, osc_cnt_nxt;
  ecc_wstate_t       st_r, st_nxt;
  logic [7:0]        rdata_r, rdata_nxt;
  logic              irq_r,  irq_nxt;
  logic              stall_busy;
  logic              stall_r, stall_nxt;
  logic              wr_launch, rd_launch, wr_ctrl, done;

  localparam logic [12:0] WR_OSC_LAST = 13'(WR_OSC_CYC - 1);

  assign wr_ctrl   = i_io_wr && (i_io_addr == CTRL_OFS);
  // strobe honoured only with the arm bit still up and no write running
  assign wr_launch = wr_ctrl && i_io_wdata[CTRL_WR_BIT] && arm_r && !wr_r;
  // a read issued during a write is the software's fault; it still reads
  assign rd_launch = wr_ctrl && i_io_wdata[CTRL_RD_BIT];
  assign done      = (st_r == ECC_WRITE) && i_osc_tick && (osc_cnt_r == WR_OSC_LAST);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    addr_nxt    = addr_r;
    data_nxt    = data_r;
    rie_nxt     = rie_r;
    arm_nxt     = arm_r;
    wr_nxt      = wr_r;
    arm_cnt_nxt = arm_cnt_r;
    osc_cnt_nxt = osc_cnt_r;
    st_nxt      = st_r;
    rdata_nxt   = 8'h00;
    if (i_io_wr && i_io_addr == ADDR_OFS) addr_nxt = i_io_wdata[AW-1:0];
    if (i_io_wr && i_io_addr == DATA_OFS) data_nxt = i_io_wdata;
    // arm countdown
    if (arm_r) begin
      if (arm_cnt_r == 3'(ARM_CYC - 1)) begin
        arm_nxt = 1'b0;
      end else begin
        arm_cnt_nxt = arm_cnt_r + 3'h1;
      end
    end
    if (wr_ctrl) begin
      rie_nxt = i_io_wdata[CTRL_RIE_BIT];
      // arming needs the strobe written as zero in the same access
      if (i_io_wdata[CTRL_ARM_BIT] && !i_io_wdata[CTRL_WR_BIT]) begin
        arm_nxt     = 1'b1;
        arm_cnt_nxt = 3'h0;
      end
    end
    if (rd_launch) data_nxt = mem[addr_r];
    case (st_r)
      ECC_IDLE: begin
        if (wr_launch) begin
          wr_nxt      = 1'b1;
          st_nxt      = ECC_WRITE;
          osc_cnt_nxt = 13'h0;
        end
      end
      ECC_WRITE: begin
        if (i_io_wr && (i_io_addr == ADDR_OFS || i_io_addr == DATA_OFS)) begin
          // abort: cell content left as it was, treated as undefined
          wr_nxt = 1'b0;
          st_nxt = ECC_IDLE;
        end else if (done) begin
          wr_nxt = 1'b0;
          st_nxt = ECC_IDLE;
        end else if (i_osc_tick) begin
          osc_cnt_nxt = osc_cnt_r + 13'h1;
        end
      end
      default: begin
        st_nxt = ECC_IDLE;
        wr_nxt = 1'b0;
      end
    endcase
    if (i_io_rd) begin
      case (i_io_addr)
        ADDR_OFS: rdata_nxt = {2'b00, addr_r};
        DATA_OFS: rdata_nxt = data_r;
        CTRL_OFS: rdata_nxt = {4'h0, rie_r, arm_r, wr_r, 1'b0};
        default:  rdata_nxt = 8'h00;
      endcase
    end
    irq_nxt   = rie_nxt && i_global_ie && !wr_nxt;
    // launch cycle set here; the counter carries the tail of the stall
    stall_nxt = wr_launch || rd_launch || stall_busy;
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // address and data sit outside reset so their contents survive it
  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      addr_r <= addr_nxt;
      data_r <= data_nxt;
      if (done) mem[addr_r] <= data_r;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rie_r     <= CTRL_RST[CTRL_RIE_BIT];
      arm_r     <= CTRL_RST[CTRL_ARM_BIT];
      wr_r      <= CTRL_RST[CTRL_WR_BIT];
      arm_cnt_r <= 3'h0;
      osc_cnt_r <= 13'h0;
      st_r      <= ECC_IDLE;
      rdata_r   <= 8'h00;
      irq_r     <= 1'b0;
      stall_r   <= 1'b0;
    end else if (i_ce) begin
      rie_r     <= rie_nxt;
      arm_r     <= arm_nxt;
      wr_r      <= wr_nxt;
      arm_cnt_r <= arm_cnt_nxt;
      osc_cnt_r <= osc_cnt_nxt;
      st_r      <= st_nxt;
      rdata_r   <= rdata_nxt;
      irq_r     <= irq_nxt;
      stall_r   <= stall_nxt;
    end
  end

  // ---------------------------------------------------------------
  // cpu stall
  // ---------------------------------------------------------------
  logic [2:0] stall_cnt_val;
  assign stall_cnt_val = rd_launch ? 3'(RD_STALL_CYC - 1) : 3'(WR_STALL_CYC - 1);

  ecc_stall_cnt u_stall (
    .i_clk    (i_clk),
    .i_rstn   (i_rstn),
    .i_ce     (i_ce),
    .i_load   (wr_launch || rd_launch),
    .i_cycles (stall_cnt_val),
    .o_busy   (stall_busy)
  );

  assign o_io_rdata  = rdata_r;
  assign o_cpu_stall = stall_r;
  assign o_ready_irq = irq_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_arm_timeout: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_ce && wr_ctrl && i_io_wdata[CTRL_ARM_BIT] && !i_io_wdata[CTRL_WR_BIT]) ##1 i_ce[*4]
      |=> !arm_r)
    else $error("arm bit did not time out");
  a_strobe_needs_arm: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_ce && st_r == ECC_IDLE && !arm_r) |=> (st_r == ECC_IDLE))
    else $error("write started without arm");
  a_wr_stall_len: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_ce && wr_launch && !rd_launch) ##1 (i_ce && !rd_launch)
      ##1 (i_ce && !rd_launch && !wr_launch) |-> o_cpu_stall ##1 !o_cpu_stall)
    else $error("write stall length wrong");
  a_rd_stall_len: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_ce && rd_launch) |=> o_cpu_stall[*4])
    else $error("read stall too short");
  a_irq_level: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_ce && $past(i_ce) && wr_r) |-> !o_ready_irq)
    else $error("irq during write");
  a_addr_upper: assert property (@(posedge i_clk) disable iff (!i_rstn)
    ($past(i_io_rd) && $past(i_ce) && $past(i_io_addr) == ADDR_OFS) |-> o_io_rdata[7:6] == 2'b00)
    else $error("address upper bits not zero");
  a_ctrl_reserved: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_io_rdata[7:4] == 4'h0 || $past(i_io_addr) != CTRL_OFS || !$past(i_io_rd)
      || !$past(i_ce))
    else $error("reserved control bits set");
  a_write_clears: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_ce && done) |=> !wr_r)
    else $error("write strobe not cleared at end");
  a_abort_write: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_ce && st_r == ECC_WRITE && i_io_wr && i_io_addr == DATA_OFS) |=> st_r == ECC_IDLE)
    else $error("write not aborted");
endmodule
`default_nettype wire

// file: verilog/ecc_stall_cnt.sv
`default_nettype none
// ---------------------------------------------------------------
// cpu stall timer: counts loaded cycles down, busy while nonzero
// ---------------------------------------------------------------
module ecc_stall_cnt (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_ce,
  // control
  input  wire logic       i_load,
  input  wire logic [2:0] i_cycles,
  // status
  output logic            o_busy
);
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (i_load) begin
      cnt_nxt = i_cycles;
    end else if (cnt_r != 3'h0) begin
      cnt_nxt = cnt_r - 3'h1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_r <= 3'h0;
    end else if (i_ce) begin
      cnt_r <= cnt_nxt;
    end
  end

  assign o_busy = (cnt_r != 3'h0);
endmodule
`default_nettype wire
